// ==== bench/spimsp_core_properties.sv ====
`timescale 1ns/10ps
module spimsp_core_props (
  // clock and register port
  input wire clk_i,
  input wire srst_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  // outputs and select pin
  input wire irq_o,
  input wire sck_o,
  input wire sck_oe_o,
  input wire mosi_oe_o,
  input wire miso_oe_o,
  input wire ss_n_i,
  input wire port_owns_pins_o,
  input wire sel_pin_owned_o
);
  reg [7:0] cr_q;
  reg [7:0] sr_q;
  reg [7:0] cnt_q;
  reg sck_q;
  reg [7:0] half;
  always @* begin
    case ({cr_q[5], cr_q[1:0]})
      3'b100: half = 8'h02;
      3'b000: half = 8'h04;
      3'b001: half = 8'h08;
      3'b110: half = 8'h10;
      3'b010: half = 8'h20;
      default: half = 8'h40;
    endcase
  end
  // shadows of software writes; fault clears are not mirrored, so only stable bits are used
  always @(posedge clk_i) begin
    if (srst_i) begin
      cr_q <= 8'h00;
      sr_q <= 8'h00;
      cnt_q <= 8'h00;
      sck_q <= 1'b0;
    end else begin
      if (wr_i && addr_i == 8'h22) begin
        cr_q <= wdata_i;
      end
      if (wr_i && addr_i == 8'h23) begin
        sr_q <= wdata_i;
      end
      sck_q <= sck_o;
      cnt_q <= (sck_o != sck_q) ? 8'h01 : cnt_q + {7'h00, cnt_q != 8'hFF};
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence s_cfg;
    wr_i && addr_i == 8'h22 && wdata_i[6] && wdata_i[4] && ss_n_i && !sr_q[1];
  endsequence
  sequence s_sel_low;
    (sck_oe_o && !ss_n_i && !sr_q[1]) [*8];
  endsequence
  property p_irq_mask; !cr_q[7] |-> !irq_o; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
  property p_pins_free; !port_owns_pins_o |-> !(sck_oe_o || mosi_oe_o || miso_oe_o); endproperty
  a_pins_free: assert property (p_pins_free) else $error("pin driven while off");
  property p_dir; (mosi_oe_o |-> sck_oe_o) and (miso_oe_o |-> !sck_oe_o); endproperty
  a_dir: assert property (p_dir) else $error("pin direction wrong");
  property p_out_dis; sr_q[2] |-> !mosi_oe_o && !miso_oe_o; endproperty
  a_out_dis: assert property (p_out_dis) else $error("data out while disabled");
  property p_sel_pin; sel_pin_owned_o == (port_owns_pins_o && !sr_q[1]); endproperty
  a_sel_pin: assert property (p_sel_pin) else $error("select pin ownership");
  property p_idle; s_cfg |-> ##2 (sck_o == $past(wdata_i[3], 2)); endproperty
  a_idle: assert property (p_idle) else $error("clock idle level");
  property p_half; sck_oe_o && $past(sck_oe_o, 3) && sck_o != sck_q |-> cnt_q >= half; endproperty
  a_half: assert property (p_half) else $error("clock half period short");
  property p_fault; s_sel_low |=> !sck_oe_o; endproperty
  a_fault: assert property (p_fault) else $error("master kept with select low");
endmodule // spimsp_core_props
bind spimsp_core spimsp_core_props u_spimsp_core_props (.clk_i(clk_i), .srst_i(srst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .irq_o(irq_o), .sck_o(sck_o),
  .sck_oe_o(sck_oe_o), .mosi_oe_o(mosi_oe_o), .miso_oe_o(miso_oe_o), .ss_n_i(ss_n_i),
  .port_owns_pins_o(port_owns_pins_o), .sel_pin_owned_o(sel_pin_owned_o));

// ==== bench/spimsp_slave_model.sv ====
`timescale 1ns/10ps
module spimsp_slave_model (
  // mode and data
  input wire clock_idle_level_i,
  input wire clock_capture_phase_i,
  input wire [7:0] tx_i,
  input wire arm_i,
  // serial lines
  input wire sck_i,
  input wire mosi_i,
  output reg miso_o,
  output reg [7:0] rx_o
);
  reg [7:0] sh_q;
  integer nin = 8;
  integer nout = 8;
  initial begin
    miso_o = 1'b0;
    rx_o = 8'h00;
    sh_q = 8'h00;
  end
  always @(arm_i) begin
    sh_q = tx_i;
    nin = 0;
    nout = 0;
    if (!clock_capture_phase_i) begin
      miso_o = tx_i[7];
      nout = 1;
    end
  end
  // outside a frame the line toggles so no stale bit can pass as data
  always @(sck_i) begin
    if (nin < 8 && ((sck_i != clock_idle_level_i) ^ clock_capture_phase_i)) begin
      rx_o = {rx_o[6:0], mosi_i};
      nin = nin + 1;
      if (nin == 8) begin
        miso_o = ~miso_o;
      end
    end else if (nin < 8 && nout < 8) begin
      miso_o = sh_q[7 - nout];
      nout = nout + 1;
    end else begin
      miso_o = ~miso_o;
    end
  end
endmodule // spimsp_slave_model

// ==== bench/testbench.sv ====
`timescale 1ns/10ps
module testbench;
  reg clk_i = 1'b0;
  reg srst_i = 1'b1;
  reg [7:0] addr_i = 8'h00;
  reg [7:0] wdata_i = 8'h00;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  reg ss_n = 1'b1;
  reg clock_idle_level = 1'b0;
  reg clock_capture_phase = 1'b0;
  reg arm = 1'b0;
  reg [7:0] s_tx = 8'h00;
  reg [7:0] d;
  wire [7:0] rdata_o, s_rx;
  wire irq_o, sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o, s_miso, own_o, sel_o;
  wire sck_w = sck_oe_o ? sck_o : clock_idle_level;
  wire mosi_w = mosi_oe_o ? mosi_o : ~mosi_o;
  wire miso_w = miso_oe_o ? miso_o : s_miso;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int tog = 0;
  int i;
  time t0, t1;
  logic [2:0] codes [6] = '{3'b100, 3'b000, 3'b001, 3'b110, 3'b010, 3'b011};
  int halves [6] = '{2, 4, 8, 16, 32, 64};
  logic [7:0] srs [4] = '{8'h00, 8'h03, 8'h02, 8'h04};
  logic ssns [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
  logic fs [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  spimsp_core u_spimsp_core (.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .sck_i(sck_w), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .mosi_i(mosi_w), .mosi_o(mosi_o),
    .mosi_oe_o(mosi_oe_o), .miso_i(miso_w), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
    .ss_n_i(ss_n), .port_owns_pins_o(own_o), .sel_pin_owned_o(sel_o));
  spimsp_slave_model u_spimsp_slave_model (.clock_idle_level_i(clock_idle_level), .clock_capture_phase_i(clock_capture_phase), .tx_i(s_tx),
    .arm_i(arm), .sck_i(sck_w), .mosi_i(mosi_w), .miso_o(s_miso), .rx_o(s_rx));
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  always @(sck_o) if (sck_oe_o) begin
    if (tog == 0) t0 = $time;
    t1 = $time;
    tog = tog + 1;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      tally_and_finish;
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task wr_reg(input [7:0] a, input [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task rd_reg(input [7:0] a, output [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (e !== g) begin
      err_count++;
      $display("[ERR] %s expected %0h got %0h", nm, e, g);
    end
  endtask
  task tally_and_finish;
    if (err_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // one master byte; k bounds the wait, the last pass also collides
  task automatic xfer(input int n);
    logic [7:0] ctl, tx, sl;
    int h, k;
    h = halves[n % 6];
    tx = $urandom;
    sl = (n == 0) ? 8'h81 : $urandom;
    ctl = 8'hD0 | {2'b00, codes[n % 6][2], 1'b0, n[1:0], codes[n % 6][1:0]};
    clock_idle_level = n[1];
    clock_capture_phase = n[0];
    s_tx = sl;
    wr_reg(8'h22, 8'h00);
    wr_reg(8'h22, ctl);
    repeat (3) @(posedge clk_i);
    tog = 0;
    arm = ~arm;
    wr_reg(8'h21, tx);
    if (n == 6) begin
      repeat (6) @(posedge clk_i);
      wr_reg(8'h21, ~tx);
    end
    k = 0;
    while (irq_o !== 1'b1 && k < 3000) begin
      @(posedge clk_i);
      k++;
    end
    chk("irq", 1'b1, irq_o);
    chk("span", 15 * h * 25, 32'(t1 - t0));
    wr_reg(8'h21, 8'h5A);
    repeat (2 * h) @(posedge clk_i);
    chk("idle", ctl[3], sck_o);
    chk("tog", 16, tog);
    rd_reg(8'h23, d);
    chk("csr", (n == 6) ? 8'hC0 : 8'h80, d);
    rd_reg(8'h21, d);
    chk("rx", sl, d);
    chk("tx", tx, s_rx);
    rd_reg(8'h23, d);
    chk("csr clr", 8'h00, d);
    chk("irq clr", 1'b0, irq_o);
  endtask
  task automatic fault(input int n);
    logic f;
    f = fs[n];
    wr_reg(8'h23, srs[n]);
    wr_reg(8'h22, 8'hD0);
    ss_n <= ssns[n];
    repeat (12) @(posedge clk_i);
    chk("oe", {!f, !f && !srs[n][2]}, {sck_oe_o, mosi_oe_o});
    chk("irq", f, irq_o);
    rd_reg(8'h23, d);
    chk("csr", srs[n] | {3'b000, f, 4'h0}, d);
    rd_reg(8'h22, d);
    chk("ctrl", f ? 8'h80 : 8'hD0, d);
    ss_n <= 1'b1;
    wr_reg(8'h22, 8'h00);
    wr_reg(8'h23, 8'h00);
    rd_reg(8'h23, d);
    chk("csr clr", 8'h00, d);
  endtask
  initial begin
    void'($urandom(32'hd12384bc));
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b0;
    rd_reg(8'h23, d);
    chk("csr rst", 8'h00, d);
    rd_reg(8'h22, d);
    chk("ctrl rst", 8'h00, d & 8'hF0);
    rd_reg(8'h20, d);
    chk("unmapped", 8'h00, d);
    chk("pins", 1'b0, own_o);
    for (i = 0; i < 7; i++) xfer(i);
    for (i = 0; i < 4; i++) fault(i);
    tally_and_finish;
  end
endmodule // testbench

// ==== common/spimsp_map.vh ====
`ifndef SPIMSP_MAP_VH
`define SPIMSP_MAP_VH
// ----------------------------------------
// register indices (byte addresses of the port)
// ----------------------------------------
`define SPIMSP_ADDR_DATA 8'h21
`define SPIMSP_ADDR_CTRL 8'h22
`define SPIMSP_ADDR_CSR 8'h23
// ----------------------------------------
// control register fields
// ----------------------------------------
`define SPIMSP_CR_IRQ_EN 7
`define SPIMSP_CR_PORT_EN 6
`define SPIMSP_CR_DIV_HIGH 5
`define SPIMSP_CR_MASTER 4
`define SPIMSP_CR_IDLE_LVL 3
`define SPIMSP_CR_PHASE 2
`define SPIMSP_CR_DIV_MID 1
`define SPIMSP_CR_DIV_LOW 0
// ----------------------------------------
// control/status register fields
// ----------------------------------------
`define SPIMSP_SR_DONE 7
`define SPIMSP_SR_WRITE_COLLISION_FLAG 6
`define SPIMSP_SR_OVR 5
`define SPIMSP_SR_MODE_FAULT_FLAG 4
`define SPIMSP_SR_RSVD 3
`define SPIMSP_SR_OUT_DIS 2
`define SPIMSP_SR_SEL_MGMT 1
`define SPIMSP_SR_INT_SEL 0
// ----------------------------------------
// reset values
// ----------------------------------------
`define SPIMSP_CR_RESET 8'h00
`define SPIMSP_CSR_RESET 8'h00
`define SPIMSP_DATA_RESET 8'h00
// ----------------------------------------
// timing: half periods of the serial clock in cpu cycles
// ----------------------------------------
`define SPIMSP_HALF_DIV4 7'h02
`define SPIMSP_HALF_DIV8 7'h04
`define SPIMSP_HALF_DIV16 7'h08
`define SPIMSP_HALF_DIV32 7'h10
`define SPIMSP_HALF_DIV64 7'h20
`define SPIMSP_HALF_DIV128 7'h40
`define SPIMSP_BITS_PER_XFER 4'h8
`endif

// ==== src/spimsp_core.v ====
`timescale 1ns/10ps
`include "spimsp_map.vh"

// Overview of operation
// - interrupt raised when enabled and transfer-done, mode-fault or overrun flag set.
// - pins left to general i/o while port disabled; serial functions when enabled.
// - master clock divisor from three divider bits: /4,/8,/16,/32,/64,/128.
// - divider bits ignored in slave mode; clock comes from external master.
// - master bit makes clock pin output and swaps data pin directions.
// - idle level bit sets serial clock idle level in both modes.
// - phase 0 captures on first edge; phase 1 captures on second edge.
// - done flag sets at byte end; status access then data access clears.
// - data writes ignored while done flag set until status register accessed.
// - data write during transfer sets collision flag; transfer continues.
// - overrun set when byte completes while done flag set; status read clears.
// - low select in master sets mode fault, clears enable and master.
// - output disable bit stops driving the serial data output.
// - select management picks internal bit or external select pin.
// - internal select bit 0 selects slave, 1 deselects.
// - master data write starts one byte of transmit and receive.
// - received byte copied to read buffer at byte end; slave phase 1 copies the shift register one capture early; data reads return it.
// - data write loads shift register directly, no transmit buffer.
// - after overrun buffer keeps first byte after last clear; later bytes lost.
// - collision flag never raises an interrupt.
module spimsp_core (
  // clock, reset, enable
  input wire clk_i,
  input wire srst_i,
  input wire ce_i,
  // register port
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // interrupt
  output wire irq_o,
  // serial clock pin
  input wire sck_i,
  output reg sck_o,
  output wire sck_oe_o,
  // master-out pin
  input wire mosi_i,
  output reg mosi_o,
  output wire mosi_oe_o,
  // slave-out pin
  input wire miso_i,
  output reg miso_o,
  output wire miso_oe_o,
  // slave select pin (input only)
  input wire ss_n_i,
  // pin ownership: high while serial functions own the pins
  output wire port_owns_pins_o,
  output wire sel_pin_owned_o
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_LEAD = 3'b010;
  localparam [2:0] ST_TRAIL = 3'b100;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [7:0] ctrl_q;
  reg done_q;
  reg write_collision_flag_q;
  reg ovr_q;
  reg mode_fault_flag_q;
  reg out_dis_q;
  reg sel_mgmt_q;
  reg int_sel_q;
  reg [7:0] shift_q;
  reg [7:0] rxbuf_q;
  reg [2:0] state_q;
  reg [3:0] bit_cnt_q;
  reg [6:0] div_cnt_q;
  reg sr_seen_q;
  reg mode_fault_flag_seen_q;
  reg sck_prev_q;
  reg busy_slv_q;
  // capture and end strobes delayed by the synchroniser latency
  reg [3:0] cap_dly_q;
  reg [3:0] end_dly_q;
  reg [7:0] mrx_q;

  wire [2:0] pins_sync;
  wire sck_s;
  wire mosi_s;
  wire miso_s;
  wire ss_pin_s;

  spimsp_sync #(
    .WIDTH(3),
    .INIT(3'b000)
  ) u_sync_data (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .async_i({sck_i, mosi_i, miso_i}),
    .sync_o(pins_sync)
  );

  wire [0:0] ss_sync;
  spimsp_sync #(
    .WIDTH(1),
    .INIT(1'b1)
  ) u_sync_sel (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .async_i(ss_n_i),
    .sync_o(ss_sync)
  );

  assign sck_s = pins_sync[2];
  assign mosi_s = pins_sync[1];
  assign miso_s = pins_sync[0];
  assign ss_pin_s = ss_sync[0];

  wire irq_en = ctrl_q[`SPIMSP_CR_IRQ_EN];
  wire port_en = ctrl_q[`SPIMSP_CR_PORT_EN];
  wire master = ctrl_q[`SPIMSP_CR_MASTER];
  wire idle_lvl = ctrl_q[`SPIMSP_CR_IDLE_LVL];
  wire phase = ctrl_q[`SPIMSP_CR_PHASE];

  // internal select: software bit or pin
  wire sel_n = sel_mgmt_q ? int_sel_q : ss_pin_s;

  // ----------------------------------------
  // pin control
  // ----------------------------------------
  assign port_owns_pins_o = port_en;
  assign sel_pin_owned_o = port_en & ~sel_mgmt_q;
  assign sck_oe_o = port_en & master;
  assign mosi_oe_o = port_en & master & ~out_dis_q;
  // slave drives its output only while selected, to share the line
  assign miso_oe_o = port_en & ~master & ~sel_n & ~out_dis_q;

  // interrupt; collision flag excluded
  assign irq_o = irq_en & (done_q | mode_fault_flag_q | ovr_q);

  // ----------------------------------------
  // master clock divider
  // ----------------------------------------
  reg [6:0] half_div;
  always @* begin
    // divider bits only consulted by the master engine
    case ({ctrl_q[`SPIMSP_CR_DIV_HIGH], ctrl_q[`SPIMSP_CR_DIV_MID], ctrl_q[`SPIMSP_CR_DIV_LOW]})
      3'b100: half_div = `SPIMSP_HALF_DIV4;
      3'b000: half_div = `SPIMSP_HALF_DIV8;
      3'b001: half_div = `SPIMSP_HALF_DIV16;
      3'b110: half_div = `SPIMSP_HALF_DIV32;
      3'b010: half_div = `SPIMSP_HALF_DIV64;
      3'b011: half_div = `SPIMSP_HALF_DIV128;
      default: half_div = `SPIMSP_HALF_DIV128;
    endcase
  end

  // ----------------------------------------
  // register access decode
  // ----------------------------------------
  wire wr_data = wr_i & (addr_i == `SPIMSP_ADDR_DATA);
  wire wr_ctrl = wr_i & (addr_i == `SPIMSP_ADDR_CTRL);
  wire wr_csr = wr_i & (addr_i == `SPIMSP_ADDR_CSR);
  wire rd_data = rd_i & (addr_i == `SPIMSP_ADDR_DATA);
  wire rd_csr = rd_i & (addr_i == `SPIMSP_ADDR_CSR);
  wire acc_csr = wr_csr | rd_csr;
  wire acc_data = wr_data | rd_data;

  wire busy = (state_q != ST_IDLE) | busy_slv_q | (|end_dly_q);
  // write blocked while done flag pending and status not yet accessed
  wire wr_block = done_q & ~sr_seen_q;
  wire collide = wr_data & busy & ~wr_block;
  wire load = wr_data & ~busy & ~wr_block & port_en;
  wire fault = port_en & master & ~sel_n;

  // ----------------------------------------
  // slave edge detection on synchronised clock
  // ----------------------------------------
  wire slv_act = port_en & ~master & ~sel_n;
  wire sck_edge = slv_act & (sck_s ^ sck_prev_q);
  // leading edge leaves idle level; capture on it when phase is 0
  wire lead_edge = sck_edge & (sck_prev_q == idle_lvl);
  wire cap_edge = sck_edge & (lead_edge ^ phase);
  wire shf_edge = sck_edge & ~(lead_edge ^ phase);

  // ----------------------------------------
  // master engine tick
  // ----------------------------------------
  wire tick = (div_cnt_q == half_div - 7'h01);
  wire m_last = (state_q == ST_TRAIL) & tick & (bit_cnt_q == `SPIMSP_BITS_PER_XFER - 4'h1);
  wire s_last = cap_edge & (bit_cnt_q == `SPIMSP_BITS_PER_XFER - 4'h1) & phase |
                shf_edge & (bit_cnt_q == `SPIMSP_BITS_PER_XFER) & ~phase;
  wire m_run = master & port_en & ~fault;
  // master capture point; miso seen four cycles later through the synchroniser
  wire m_cap = m_run & tick & ((state_q == ST_LEAD) & ~phase | (state_q == ST_TRAIL) & phase);
  wire [7:0] mrx_next = {mrx_q[6:0], miso_s};
  wire xfer_end = end_dly_q[3] | (s_last & ~master);
  wire [7:0] mrx_byte = cap_dly_q[3] ? mrx_next : mrx_q;
  wire [7:0] rx_byte = end_dly_q[3] ? mrx_byte : shift_q;

  always @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_q <= `SPIMSP_CR_RESET;
      {done_q, write_collision_flag_q, ovr_q, mode_fault_flag_q} <= 4'h0;
      {out_dis_q, sel_mgmt_q, int_sel_q} <= 3'h0;
      shift_q <= `SPIMSP_DATA_RESET;
      rxbuf_q <= `SPIMSP_DATA_RESET;
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      div_cnt_q <= 7'h00;
      sr_seen_q <= 1'b0;
      mode_fault_flag_seen_q <= 1'b0;
      sck_prev_q <= 1'b0;
      busy_slv_q <= 1'b0;
      cap_dly_q <= 4'h0;
      end_dly_q <= 4'h0;
      mrx_q <= 8'h00;
      sck_o <= 1'b0;
      mosi_o <= 1'b0;
      miso_o <= 1'b0;
      rdata_o <= 8'h00;
    end else if (ce_i) begin
      sck_prev_q <= sck_s;
      cap_dly_q <= {cap_dly_q[2:0], m_cap};
      end_dly_q <= {end_dly_q[2:0], m_last & m_run};
      if (cap_dly_q[3]) mrx_q <= mrx_next;
      rdata_o <= 8'h00;
      if (rd_data) rdata_o <= rxbuf_q;
      if (rd_csr) begin
        rdata_o <= {done_q, write_collision_flag_q, ovr_q, mode_fault_flag_q, 1'b0, out_dis_q, sel_mgmt_q, int_sel_q};
      end
      if (rd_i & (addr_i == `SPIMSP_ADDR_CTRL)) rdata_o <= ctrl_q;

      // status-access tracking for two-step clears
      if (acc_csr) sr_seen_q <= 1'b1;
      else if (acc_data) sr_seen_q <= 1'b0;
      if (acc_csr & mode_fault_flag_q) mode_fault_flag_seen_q <= 1'b1;

      // control write; enable/master held low while fault flag set and not yet seen by a status access
      if (wr_ctrl) begin
        ctrl_q <= wdata_i;
        if (mode_fault_flag_q & ~mode_fault_flag_seen_q) begin
          ctrl_q[`SPIMSP_CR_PORT_EN] <= 1'b0;
          ctrl_q[`SPIMSP_CR_MASTER] <= 1'b0;
        end
      end
      if (wr_csr) begin
        // reserved bit 3 kept zero regardless of software
        out_dis_q <= wdata_i[`SPIMSP_SR_OUT_DIS];
        sel_mgmt_q <= wdata_i[`SPIMSP_SR_SEL_MGMT];
        int_sel_q <= wdata_i[`SPIMSP_SR_INT_SEL];
      end

      // done flag: clear by status then data access; set wins
      if (acc_data & sr_seen_q) done_q <= 1'b0;
      // collision flag uses the same sequence
      if (acc_data & sr_seen_q) write_collision_flag_q <= 1'b0;
      if (collide) write_collision_flag_q <= 1'b1;
      // overrun clears on status read
      if (rd_csr) ovr_q <= 1'b0;
      // fault clears on status access while set then control write
      if (wr_ctrl & mode_fault_flag_seen_q) begin
        mode_fault_flag_q <= 1'b0;
        mode_fault_flag_seen_q <= 1'b0;
      end

      if (xfer_end) begin
        if (done_q & ~(acc_data & sr_seen_q)) begin
          ovr_q <= 1'b1; // buffer kept
        end else begin
          rxbuf_q <= rx_byte;
          done_q <= 1'b1;
          // a status access before the flag rose does not count
          if (!acc_csr) sr_seen_q <= 1'b0;
        end
      end

      if (fault) begin
        mode_fault_flag_q <= 1'b1;
        mode_fault_flag_seen_q <= 1'b0;
        ctrl_q[`SPIMSP_CR_PORT_EN] <= 1'b0;
        ctrl_q[`SPIMSP_CR_MASTER] <= 1'b0;
      end

      // ----------------------------------------
      // transfer engine
      // ----------------------------------------
      if (load) begin
        shift_q <= wdata_i;
        bit_cnt_q <= 4'h0;
        div_cnt_q <= 7'h00;
        if (master) begin
          state_q <= ST_LEAD;
          mosi_o <= wdata_i[7];
        end else begin
          miso_o <= wdata_i[7];
        end
      end else if (master & port_en & ~fault) begin
        case (state_q)
          ST_IDLE: begin
            sck_o <= idle_lvl;
            div_cnt_q <= 7'h00;
          end
          ST_LEAD: begin
            div_cnt_q <= tick ? 7'h00 : div_cnt_q + 7'h01;
            if (tick) begin
              sck_o <= ~idle_lvl;
              state_q <= ST_TRAIL;
              if (phase) mosi_o <= shift_q[7]; // shift on first edge
            end
          end
          ST_TRAIL: begin
            div_cnt_q <= tick ? 7'h00 : div_cnt_q + 7'h01;
            if (tick) begin
              sck_o <= idle_lvl;
              bit_cnt_q <= bit_cnt_q + 4'h1;
              // msb first, out only; received bits collect in mrx_q
              shift_q <= {shift_q[6:0], 1'b0};
              if (~phase) mosi_o <= shift_q[6];
              state_q <= m_last ? ST_IDLE : ST_LEAD;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end else begin
        state_q <= ST_IDLE;
        sck_o <= idle_lvl;
        // slave engine follows the external clock
        if (slv_act) begin
          if (sck_edge & ~busy_slv_q) begin
            busy_slv_q <= 1'b1;
            bit_cnt_q <= 4'h0;
          end
          if (cap_edge) begin
            shift_q <= {shift_q[6:0], mosi_s};
            bit_cnt_q <= (sck_edge & ~busy_slv_q) ? 4'h1 : bit_cnt_q + 4'h1;
          end
          if (shf_edge & busy_slv_q) miso_o <= shift_q[7];
          if (xfer_end) busy_slv_q <= 1'b0;
        end else begin
          busy_slv_q <= 1'b0;
          bit_cnt_q <= 4'h0;
        end
      end
    end
  end

endmodule // spimsp_core

// ==== src/spimsp_sync.v ====
`timescale 1ns/10ps
`include "spimsp_map.vh"

// three-stage synchroniser; change counts when stages two and three agree
module spimsp_sync #(
  parameter WIDTH = 3,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  // clock and control
  input wire clk_i,
  input wire srst_i,
  input wire ce_i,
  // data
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;

  always @(posedge clk_i) begin
    if (srst_i) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      sync_o <= INIT;
    end else if (ce_i) begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // per-bit agreement filter; hold on disagreement
      sync_o <= (s3_q & ~(s2_q ^ s3_q)) | (sync_o & (s2_q ^ s3_q));
    end
  end

endmodule // spimsp_sync
